// ==== hdl/rcsl_defines.svh ====
// constants for the reset cause and reset state logic
`ifndef RCSL_DEFINES_SVH
`define RCSL_DEFINES_SVH
`define RCSL_PC_W 21
`define RCSL_RESET_VECTOR 21'h000000
`define RCSL_HIGH_INT_VECTOR 21'h000008
`define RCSL_LOW_INT_VECTOR 21'h000018
`define RCSL_WAKE_PC_STEP 21'h000002
`define RCSL_BOR_CFG_SOFT 2'h1
`define RCSL_INTB_RESET 8'hFF
`define RCSL_INTC_RESET 8'hC0
`define RCSL_BYTE_ZERO 8'h00
`define RCSL_SP_PTR_ZERO 5'h00
`define RCSL_RC_SOFT_BROWNOUT_ENABLE_BIT 6
`define RCSL_RC_RI_BIT 4
`define RCSL_RC_TO_BIT 3
`define RCSL_RC_PD_BIT 2
`define RCSL_RC_POR_BIT 1
`define RCSL_RC_BOR_BIT 0
`define RCSL_SP_FUL_BIT 7
`define RCSL_SP_UNF_BIT 6
`endif

// ==== hdl/rcsl_pkg.sv ====
// types for the reset cause and reset state logic
package rcsl_pkg;
    typedef enum logic [1:0] {
        RCSL_MODE_FULL,
        RCSL_MODE_RUN,
        RCSL_MODE_IDLE,
        RCSL_MODE_SLEEP
    } rcsl_power_mode_t;

    typedef enum logic [3:0] {
        RCSL_SEL_CAUSE,
        RCSL_SEL_STACK,
        RCSL_SEL_INTA,
        RCSL_SEL_INTB,
        RCSL_SEL_INTC,
        RCSL_SEL_PROGRAM_COUNTER_LATCH_HIGH,
        RCSL_SEL_PROGRAM_COUNTER_LATCH_UPPER,
        RCSL_SEL_TBLU,
        RCSL_SEL_TBLH,
        RCSL_SEL_TBLL,
        RCSL_SEL_TABLE_LATCH_BYTE,
        RCSL_SEL_MULTIPLY_RESULT_HIGH,
        RCSL_SEL_WORKING_ACCUMULATOR,
        RCSL_SEL_INDIRECT_POINTER0_LOW
    } rcsl_reg_sel_t;

    typedef struct packed {
        logic brownout;
        logic external_reset;
        logic reset_instr;
        logic watchdog_timeout;
        logic stack_overflow;
        logic stack_underflow;
        logic wake_interrupt;
    } rcsl_events_t;

    typedef struct packed {
        logic soft_brownout_enable;
        logic reset_instr_flag;
        logic watchdog_expiry_flag;
        logic sleep_entry_flag;
        logic power_on_flag;
        logic brownout_flag;
    } rcsl_cause_t;

    typedef struct packed {
        logic stack_overflow_flag;
        logic stack_underflow_flag;
        logic [4:0] pointer;
    } rcsl_stack_t;
endpackage : rcsl_pkg

// ==== hdl/rcsl_reset_cause.sv ====
// reset cause flags, per-class register reset state and restart address choice
`timescale 1ns/1ps
`include "rcsl_defines.svh"

// Functional notes
// - unreset registers hold through non-power-on resets
// - watchdog wake resumes, most registers untouched
// - power-on: pc zero, set soft brownout enable and ri/to/pd, clear por/bor
// - reset instruction: restart zero, clear ri only
// - brownout: set ri/to/pd, clear bor flag
// - pin reset in low power sets to
// - watchdog in run: restart zero, clear to
// - pin reset at full power: flags unchanged
// - overflow with enable: restart, set overflow flag
// - underflow with enable: restart, set underflow flag
// - underflow without enable: flag only, no restart
// - wake: pc plus two, clear pd
// - interrupt wake with enables: load vector
// - soft brownout enable reset value rule
// - stack register clear per reset class
// - interrupt control reset values, kept on wake
// - table pointer/latch bytes clear; data and indirect pointer bytes preserved
// - soft brownout enable reads zero unless soft
module rcsl_reset_cause (
    input wire logic ref_clk,
    input wire logic reset,
    input wire rcsl_pkg::rcsl_events_t events,
    input wire rcsl_pkg::rcsl_power_mode_t power_mode,
    input wire logic [1:0] brownout_config_field,
    input wire logic stack_fault_reset_enable,
    input wire logic wake_int_high_priority,
    input wire logic [`RCSL_PC_W-1:0] pc_current,
    input wire logic sw_we,
    input wire rcsl_pkg::rcsl_reg_sel_t sw_sel,
    input wire logic [7:0] sw_data,
    output logic core_restart,
    output logic pc_load,
    output logic [`RCSL_PC_W-1:0] pc_load_addr,
    output logic [7:0] reset_cause_register,
    output logic [7:0] stack_pointer_register,
    output logic high_priority_int_enable,
    output logic low_priority_int_enable,
    output logic soft_brownout_enable,
    output logic [7:0] interrupt_control_a,
    output logic [7:0] interrupt_control_b,
    output logic [7:0] interrupt_control_c,
    output logic [7:0] program_counter_latch_high,
    output logic [7:0] program_counter_latch_upper,
    output logic [7:0] table_pointer_upper,
    output logic [7:0] table_pointer_high,
    output logic [7:0] table_pointer_low,
    output logic [7:0] table_latch_byte,
    output logic [7:0] multiply_result_high,
    output logic [7:0] working_accumulator,
    output logic [7:0] indirect_pointer0_low
);
    import rcsl_pkg::*;

    // ----------------------------------------
    // event classification
    // ----------------------------------------
    typedef enum {
        RCSL_EV_NONE,
        RCSL_EV_BOR,
        RCSL_EV_PIN,
        RCSL_EV_WDT_RESET,
        RCSL_EV_INSTR,
        RCSL_EV_OVF,
        RCSL_EV_UNF_RESET,
        RCSL_EV_UNF_ERROR,
        RCSL_EV_WDT_WAKE,
        RCSL_EV_INT_WAKE
    } rcsl_event_kind_t;

    rcsl_event_kind_t kind;
    logic low_power_sleep;
    logic soft_bor_mode;

    assign low_power_sleep = (power_mode == RCSL_MODE_IDLE) || (power_mode == RCSL_MODE_SLEEP);
    assign soft_bor_mode = (brownout_config_field == `RCSL_BOR_CFG_SOFT);

    always_comb begin
        if (events.brownout) begin
            kind = RCSL_EV_BOR;
        end else if (events.external_reset) begin
            kind = RCSL_EV_PIN;
        end else if (events.watchdog_timeout && !low_power_sleep) begin
            kind = RCSL_EV_WDT_RESET;
        end else if (events.reset_instr) begin
            kind = RCSL_EV_INSTR;
        end else if (events.stack_overflow && stack_fault_reset_enable) begin
            kind = RCSL_EV_OVF;
        end else if (events.stack_underflow && stack_fault_reset_enable) begin
            kind = RCSL_EV_UNF_RESET;
        end else if (events.stack_underflow) begin
            kind = RCSL_EV_UNF_ERROR;
        end else if (events.watchdog_timeout) begin
            kind = RCSL_EV_WDT_WAKE;
        end else if (events.wake_interrupt) begin
            kind = RCSL_EV_INT_WAKE;
        end else begin
            kind = RCSL_EV_NONE;
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    rcsl_cause_t cause_reg, cause_next;
    rcsl_stack_t stack_reg, stack_next;
    logic [7:0] inta_reg, inta_next;
    logic [7:0] intb_reg, intb_next;
    logic [7:0] intc_reg, intc_next;
    logic [7:0] program_counter_latch_high_reg, program_counter_latch_high_next;
    logic [4:0] program_counter_latch_upper_reg, program_counter_latch_upper_next;
    logic [5:0] tblu_reg, tblu_next;
    logic [7:0] tblh_reg, tblh_next;
    logic [7:0] tbll_reg, tbll_next;
    logic [7:0] table_latch_byte_reg, table_latch_byte_next;
    logic [7:0] multiply_result_high_reg, multiply_result_high_next;
    logic [7:0] working_accumulator_reg, working_accumulator_next;
    logic [7:0] indirect_pointer0_low_reg, indirect_pointer0_low_next;
    logic restart_reg, restart_next;
    logic load_reg, load_next;
    logic [`RCSL_PC_W-1:0] addr_reg, addr_next;
    logic is_reset;

    // the brownout reset class also restarts the core like the others
    assign is_reset = (kind != RCSL_EV_NONE) && (kind != RCSL_EV_UNF_ERROR)
        && (kind != RCSL_EV_WDT_WAKE) && (kind != RCSL_EV_INT_WAKE);

    always_comb begin
        cause_next = cause_reg;
        stack_next = stack_reg;
        inta_next = inta_reg;
        intb_next = intb_reg;
        intc_next = intc_reg;
        program_counter_latch_high_next = program_counter_latch_high_reg;
        program_counter_latch_upper_next = program_counter_latch_upper_reg;
        tblu_next = tblu_reg;
        tblh_next = tblh_reg;
        tbll_next = tbll_reg;
        table_latch_byte_next = table_latch_byte_reg;
        multiply_result_high_next = multiply_result_high_reg;
        working_accumulator_next = working_accumulator_reg;
        indirect_pointer0_low_next = indirect_pointer0_low_reg;
        restart_next = 1'b0;
        load_next = 1'b0;
        addr_next = addr_reg;

        // software writes first; a same-cycle hardware event overrides the fields it sets
        if (sw_we) begin
            case (sw_sel)
                RCSL_SEL_CAUSE: begin
                    cause_next.soft_brownout_enable = sw_data[`RCSL_RC_SOFT_BROWNOUT_ENABLE_BIT];
                    cause_next.reset_instr_flag = sw_data[`RCSL_RC_RI_BIT];
                    cause_next.power_on_flag = sw_data[`RCSL_RC_POR_BIT];
                    cause_next.brownout_flag = sw_data[`RCSL_RC_BOR_BIT];
                end
                RCSL_SEL_STACK: begin
                    stack_next.stack_overflow_flag = sw_data[`RCSL_SP_FUL_BIT];
                    stack_next.stack_underflow_flag = sw_data[`RCSL_SP_UNF_BIT];
                    stack_next.pointer = sw_data[4:0];
                end
                RCSL_SEL_INTA: inta_next = sw_data;
                RCSL_SEL_INTB: intb_next = sw_data;
                RCSL_SEL_INTC: intc_next = sw_data;
                RCSL_SEL_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high_next = sw_data;
                RCSL_SEL_PROGRAM_COUNTER_LATCH_UPPER: program_counter_latch_upper_next = sw_data[4:0];
                RCSL_SEL_TBLU: tblu_next = sw_data[5:0];
                RCSL_SEL_TBLH: tblh_next = sw_data;
                RCSL_SEL_TBLL: tbll_next = sw_data;
                RCSL_SEL_TABLE_LATCH_BYTE: table_latch_byte_next = sw_data;
                RCSL_SEL_MULTIPLY_RESULT_HIGH: multiply_result_high_next = sw_data;
                RCSL_SEL_WORKING_ACCUMULATOR: working_accumulator_next = sw_data;
                RCSL_SEL_INDIRECT_POINTER0_LOW: indirect_pointer0_low_next = sw_data;
                default: ;
            endcase
        end

        if (is_reset) begin
            restart_next = 1'b1;
            load_next = 1'b1;
            addr_next = `RCSL_RESET_VECTOR;
            // kept only while soft brownout mode and set
            cause_next.soft_brownout_enable = soft_bor_mode && cause_reg.soft_brownout_enable;
            stack_next.pointer = `RCSL_SP_PTR_ZERO;
            inta_next = {7'h00, inta_reg[0]};
            intb_next = `RCSL_INTB_RESET;
            intc_next = `RCSL_INTC_RESET;
            program_counter_latch_high_next = `RCSL_BYTE_ZERO;
            program_counter_latch_upper_next = 5'h00;
            tblu_next = 6'h00;
            tblh_next = `RCSL_BYTE_ZERO;
            tbll_next = `RCSL_BYTE_ZERO;
            table_latch_byte_next = `RCSL_BYTE_ZERO;
        end

        case (kind)
            RCSL_EV_BOR: begin
                cause_next.reset_instr_flag = 1'b1;
                cause_next.watchdog_expiry_flag = 1'b1;
                cause_next.sleep_entry_flag = 1'b1;
                cause_next.brownout_flag = 1'b0;
                stack_next = '0;
            end
            RCSL_EV_PIN: begin
                if (power_mode != RCSL_MODE_FULL) begin
                    cause_next.watchdog_expiry_flag = 1'b1;
                end
                if (low_power_sleep) begin
                    cause_next.sleep_entry_flag = 1'b0;
                end
                // full power pin reset touches no flag
            end
            RCSL_EV_WDT_RESET: begin
                cause_next.watchdog_expiry_flag = 1'b0;
            end
            RCSL_EV_INSTR: begin
                cause_next.reset_instr_flag = 1'b0;
            end
            RCSL_EV_OVF: begin
                stack_next.stack_overflow_flag = 1'b1;
            end
            RCSL_EV_UNF_RESET: begin
                stack_next.stack_underflow_flag = 1'b1;
            end
            RCSL_EV_UNF_ERROR: begin
                stack_next.stack_underflow_flag = 1'b1;
            end
            RCSL_EV_WDT_WAKE: begin
                // resume: only flags and pc move
                cause_next.watchdog_expiry_flag = 1'b0;
                cause_next.sleep_entry_flag = 1'b0;
                load_next = 1'b1;
                addr_next = pc_current + `RCSL_WAKE_PC_STEP;
            end
            RCSL_EV_INT_WAKE: begin
                cause_next.sleep_entry_flag = 1'b0;
                load_next = 1'b1;
                // vector when an enable is set
                if (high_priority_int_enable || low_priority_int_enable) begin
                    addr_next = wake_int_high_priority ? `RCSL_HIGH_INT_VECTOR : `RCSL_LOW_INT_VECTOR;
                end else begin
                    addr_next = pc_current + `RCSL_WAKE_PC_STEP;
                end
            end
            default: ;
        endcase

        // power-on overrides all
        if (reset) begin
            cause_next = '{soft_brownout_enable: 1'b1, reset_instr_flag: 1'b1,
                watchdog_expiry_flag: 1'b1, sleep_entry_flag: 1'b1,
                power_on_flag: 1'b0, brownout_flag: 1'b0};
            stack_next = '0;
            inta_next = `RCSL_BYTE_ZERO;
            intb_next = `RCSL_INTB_RESET;
            intc_next = `RCSL_INTC_RESET;
            program_counter_latch_high_next = `RCSL_BYTE_ZERO;
            program_counter_latch_upper_next = 5'h00;
            tblu_next = 6'h00;
            tblh_next = `RCSL_BYTE_ZERO;
            tbll_next = `RCSL_BYTE_ZERO;
            table_latch_byte_next = `RCSL_BYTE_ZERO;
            // unknown contents; zero is one legal pick
            multiply_result_high_next = `RCSL_BYTE_ZERO;
            working_accumulator_next = `RCSL_BYTE_ZERO;
            indirect_pointer0_low_next = `RCSL_BYTE_ZERO;
            restart_next = 1'b1;
            load_next = 1'b1;
            addr_next = `RCSL_RESET_VECTOR;
        end
    end

    // power-on is the synchronous reset, so the next-value logic covers it
    always_ff @(posedge ref_clk) begin
        cause_reg <= cause_next;
        stack_reg <= stack_next;
        inta_reg <= inta_next;
        intb_reg <= intb_next;
        intc_reg <= intc_next;
        program_counter_latch_high_reg <= program_counter_latch_high_next;
        program_counter_latch_upper_reg <= program_counter_latch_upper_next;
        tblu_reg <= tblu_next;
        tblh_reg <= tblh_next;
        tbll_reg <= tbll_next;
        table_latch_byte_reg <= table_latch_byte_next;
        multiply_result_high_reg <= multiply_result_high_next;
        working_accumulator_reg <= working_accumulator_next;
        indirect_pointer0_low_reg <= indirect_pointer0_low_next;
        restart_reg <= restart_next;
        load_reg <= load_next;
        addr_reg <= addr_next;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // reads zero outside soft mode
    assign soft_brownout_enable = cause_reg.soft_brownout_enable && soft_bor_mode;
    assign reset_cause_register = {1'b0, soft_brownout_enable, 1'b0,
        cause_reg.reset_instr_flag, cause_reg.watchdog_expiry_flag,
        cause_reg.sleep_entry_flag, cause_reg.power_on_flag, cause_reg.brownout_flag};
    assign stack_pointer_register = {stack_reg.stack_overflow_flag,
        stack_reg.stack_underflow_flag, 1'b0, stack_reg.pointer};
    assign high_priority_int_enable = inta_reg[7];
    assign low_priority_int_enable = inta_reg[6];
    assign interrupt_control_a = inta_reg;
    assign interrupt_control_b = intb_reg;
    assign interrupt_control_c = intc_reg;
    assign program_counter_latch_high = program_counter_latch_high_reg;
    assign program_counter_latch_upper = {3'h0, program_counter_latch_upper_reg};
    assign table_pointer_upper = {2'h0, tblu_reg};
    assign table_pointer_high = tblh_reg;
    assign table_pointer_low = tbll_reg;
    assign table_latch_byte = table_latch_byte_reg;
    assign multiply_result_high = multiply_result_high_reg;
    assign working_accumulator = working_accumulator_reg;
    assign indirect_pointer0_low = indirect_pointer0_low_reg;
    assign core_restart = restart_reg;
    assign pc_load = load_reg;
    assign pc_load_addr = addr_reg;
endmodule : rcsl_reset_cause

// ==== tb/rcsl_core_model.sv ====
// core side model: a program counter that steps and takes restart loads
`timescale 1ns/1ps
`include "rcsl_defines.svh"
module rcsl_core_model (
    input wire logic ref_clk,
    input wire logic pc_load,
    input wire logic [`RCSL_PC_W-1:0] pc_load_addr,
    output logic [`RCSL_PC_W-1:0] pc_current
);
    initial pc_current = '0;
    always @(posedge ref_clk) begin
        if (pc_load === 1'b1) begin
            pc_current <= pc_load_addr;
        end else begin
            pc_current <= pc_current + `RCSL_WAKE_PC_STEP;
        end
    end
endmodule : rcsl_core_model

// ==== tb/rcsl_reset_cause_checker.sv ====
// assertion checker for the reset cause and reset state logic
`timescale 1ns/1ps
`include "rcsl_defines.svh"
module rcsl_reset_cause_checker (
    input wire logic ref_clk,
    input wire logic reset,
    input wire rcsl_pkg::rcsl_events_t events,
    input wire rcsl_pkg::rcsl_power_mode_t power_mode,
    input wire logic [1:0] brownout_config_field,
    input wire logic stack_fault_reset_enable,
    input wire logic wake_int_high_priority,
    input wire logic [`RCSL_PC_W-1:0] pc_current,
    input wire logic sw_we,
    input wire logic core_restart,
    input wire logic pc_load,
    input wire logic [`RCSL_PC_W-1:0] pc_load_addr,
    input wire logic [7:0] reset_cause_register,
    input wire logic [7:0] stack_pointer_register,
    input wire logic high_priority_int_enable,
    input wire logic low_priority_int_enable,
    input wire logic soft_brownout_enable,
    input wire logic [7:0] interrupt_control_a
);
    import rcsl_pkg::*;
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (reset);
    // a lone interrupt wake with no software write racing the enables
    sequence s_wake_only;
        events == 7'h01 && !sw_we;
    endsequence
    sequence s_wake_load;
        pc_load && !core_restart;
    endsequence
    chk_por_values: assert property ($fell(reset) |-> core_restart && reset_cause_register[4:0] == 5'h1C
        && stack_pointer_register == 8'h00 && interrupt_control_a == 8'h00) else $error("power-on state wrong");
    chk_restart_addr: assert property (core_restart |-> pc_load && pc_load_addr == `RCSL_RESET_VECTOR)
        else $error("restart without zero load");
    chk_instr_reset: assert property (events == 7'h10 |=> core_restart && !reset_cause_register[4])
        else $error("reset instruction flag not cleared");
    chk_wdt_reset: assert property (events == 7'h08 && power_mode inside {RCSL_MODE_FULL, RCSL_MODE_RUN}
        |=> core_restart && !reset_cause_register[3]) else $error("watchdog reset wrong");
    chk_wake_step: assert property (s_wake_only ##0 interrupt_control_a[7:6] == 2'h0 |=> s_wake_load
        ##0 pc_load_addr == $past(pc_current) + `RCSL_WAKE_PC_STEP) else $error("wake address wrong");
    chk_wake_vector: assert property (s_wake_only ##0 interrupt_control_a[7:6] != 2'h0 |=> s_wake_load
        ##0 pc_load_addr == ($past(wake_int_high_priority) ? `RCSL_HIGH_INT_VECTOR : `RCSL_LOW_INT_VECTOR))
        else $error("wake vector wrong");
    chk_unf_error: assert property (events == 7'h02 && !stack_fault_reset_enable
        |=> stack_pointer_register[6] && !pc_load && !core_restart) else $error("underflow error wrong");
    chk_soft_brownout_enable_gate: assert property (soft_brownout_enable |-> brownout_config_field == `RCSL_BOR_CFG_SOFT
        && reset_cause_register[6]) else $error("soft brownout enable not gated");
    chk_enable_bits: assert property (high_priority_int_enable == interrupt_control_a[7]
        && low_priority_int_enable == interrupt_control_a[6]) else $error("enable bits wrong");
    chk_to_pd_hold: assert property (events == 7'h00 |=> $stable(reset_cause_register[3:2]))
        else $error("expiry or sleep flag moved");
endmodule : rcsl_reset_cause_checker

bind rcsl_reset_cause rcsl_reset_cause_checker rcsl_reset_cause_checker_i (.ref_clk(ref_clk), .reset(reset),
    .events(events), .power_mode(power_mode), .brownout_config_field(brownout_config_field),
    .stack_fault_reset_enable(stack_fault_reset_enable), .wake_int_high_priority(wake_int_high_priority),
    .pc_current(pc_current), .sw_we(sw_we), .core_restart(core_restart), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .reset_cause_register(reset_cause_register),
    .stack_pointer_register(stack_pointer_register), .high_priority_int_enable(high_priority_int_enable),
    .low_priority_int_enable(low_priority_int_enable), .soft_brownout_enable(soft_brownout_enable),
    .interrupt_control_a(interrupt_control_a));

// ==== tb/tb.sv ====
// self-checking bench for the reset cause and reset state logic
`timescale 1ns/1ps
`include "rcsl_defines.svh"
module tb;
    import rcsl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    rcsl_events_t events = '0;
    rcsl_power_mode_t power_mode = RCSL_MODE_FULL;
    logic [1:0] cfg = 2'h0;
    logic sfre = 1'b0;
    logic hp = 1'b0;
    logic sw_we = 1'b0;
    rcsl_reg_sel_t sw_sel = RCSL_SEL_CAUSE;
    logic [7:0] sw_data = 8'h00;
    logic core_restart, pc_load, rst, ld;
    logic [`RCSL_PC_W-1:0] pc_load_addr, pc_current, ea;
    logic [7:0] dout [14];
    logic [7:0] r [14];
    bit dv [14];
    logic [7:0] mc, ms;
    logic [31:0] k;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed = 32'h77d891a9;

    rcsl_reset_cause rcsl_reset_cause_i (.ref_clk(ref_clk), .reset(reset), .events(events), .power_mode(power_mode),
        .brownout_config_field(cfg), .stack_fault_reset_enable(sfre), .wake_int_high_priority(hp),
        .pc_current(pc_current), .sw_we(sw_we), .sw_sel(sw_sel), .sw_data(sw_data), .core_restart(core_restart),
        .pc_load(pc_load), .pc_load_addr(pc_load_addr), .reset_cause_register(dout[0]),
        .stack_pointer_register(dout[1]), .high_priority_int_enable(), .low_priority_int_enable(),
        .soft_brownout_enable(), .interrupt_control_a(dout[2]), .interrupt_control_b(dout[3]),
        .interrupt_control_c(dout[4]), .program_counter_latch_high(dout[5]), .program_counter_latch_upper(dout[6]),
        .table_pointer_upper(dout[7]), .table_pointer_high(dout[8]), .table_pointer_low(dout[9]),
        .table_latch_byte(dout[10]), .multiply_result_high(dout[11]), .working_accumulator(dout[12]),
        .indirect_pointer0_low(dout[13]));
    rcsl_core_model rcsl_core_model_i (.ref_clk(ref_clk), .pc_load(pc_load), .pc_load_addr(pc_load_addr),
        .pc_current(pc_current));

    initial forever #5 ref_clk = ~ref_clk;

    // --------------------------------
    // reference model
    // --------------------------------
    task automatic final_report;
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic cmp(input logic [20:0] got, input logic [20:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // unimplemented upper bits and the unknown flag bit are not compared
    function automatic logic [7:0] mask(input int i);
        case (i)
            2: return 8'hFE;
            6: return 8'h1F;
            7: return 8'h3F;
            default: return 8'hFF;
        endcase
    endfunction : mask

    task automatic other_rst;
        ms[4:0] = 5'h00;
        mc[6] = mc[6] & (cfg == 2'h1);
        r[2] = r[2] & 8'h01;
        r[3] = 8'hFF;
        r[4] = 8'hC0;
        for (int i = 5; i < 11; i++) r[i] = 8'h00;
        rst = 1'b1;
        ld = 1'b1;
        ea = '0;
    endtask : other_rst

    task automatic model_event(input logic [6:0] e, input logic [20:0] pc);
        rst = 1'b0;
        ld = 1'b0;
        if (sw_we && sw_sel == RCSL_SEL_CAUSE) begin
            mc = {1'b0, sw_data[6], 1'b0, sw_data[4], mc[3:2], sw_data[1:0]};
        end else if (sw_we && sw_sel == RCSL_SEL_STACK) begin
            ms = sw_data & 8'hDF;
        end else if (sw_we) begin
            r[sw_sel] = sw_data;
            dv[sw_sel] = 1'b1;
        end
        if (e[6]) begin
            other_rst();
            mc[4:2] = 3'h7;
            mc[0] = 1'b0;
            ms = 8'h00;
            for (int i = 11; i < 14; i++) dv[i] = 1'b0;
        end else if (e[5]) begin
            other_rst();
            if (power_mode != RCSL_MODE_FULL) mc[3] = 1'b1;
            if (power_mode >= RCSL_MODE_IDLE) mc[2] = 1'b0;
        end else if (e[3] && power_mode <= RCSL_MODE_RUN) begin
            other_rst();
            mc[3] = 1'b0;
        end else if (e[4]) begin
            other_rst();
            mc[4] = 1'b0;
        end else if (e[2] && sfre) begin
            other_rst();
            ms[7] = 1'b1;
        end else if (e[1] && sfre) begin
            other_rst();
            ms[6] = 1'b1;
        end else if (e[1]) begin
            ms[6] = 1'b1;
        end else if (e[3]) begin
            mc[3:2] = 2'h0;
            ld = 1'b1;
            ea = pc + 21'h2;
        end else if (e[0]) begin
            mc[2] = 1'b0;
            ld = 1'b1;
            ea = (r[2][7:6] != 2'h0) ? (hp ? 21'h8 : 21'h18) : pc + 21'h2;
        end
    endtask : model_event

    // --------------------------------
    // drivers and sequence
    // --------------------------------
    task automatic step(input logic [6:0] e, input logic we, input logic [31:0] v);
        logic [20:0] pc;
        @(posedge ref_clk);
        events <= e;
        sw_we <= we;
        sw_sel <= rcsl_reg_sel_t'(v[27:24] % 14);
        sw_data <= v[7:0];
        power_mode <= rcsl_power_mode_t'(v[9:8]);
        cfg <= v[11:10];
        sfre <= v[12];
        hp <= v[13];
        #1;
        pc = pc_current;
        // model while the write strobe and mode inputs still stand
        model_event(e, pc);
        @(posedge ref_clk);
        events <= '0;
        sw_we <= 1'b0;
        #1;
        cmp(core_restart, rst);
        cmp(pc_load, ld);
        if (ld) cmp(pc_load_addr, ea);
        cmp(dout[0], mc & (cfg == 2'h1 ? 8'hFF : 8'hBF));
        cmp(dout[1], ms);
        for (int i = 2; i < 14; i++) if (dv[i]) cmp(dout[i] & mask(i), r[i] & mask(i));
    endtask : step

    task automatic do_reset;
        @(posedge ref_clk);
        reset <= 1'b1;
        repeat (8) @(posedge ref_clk);
        reset <= 1'b0;
        mc = 8'h5C;
        ms = 8'h00;
        for (int i = 0; i < 14; i++) r[i] = 8'h00;
        for (int i = 0; i < 14; i++) dv[i] = 1'b1;
        r[3] = 8'hFF;
        r[4] = 8'hC0;
    endtask : do_reset

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        do_reset();
        for (int n = 0; n < 800; n++) begin
            if (n == 400) do_reset();
            k = $random(seed);
            step(7'h00, 1'b1, k);
            k = $random(seed);
            step(k[14] ? 7'h01 << (k[17:15] % 7) : k[22:16], 1'b0, k);
        end
        final_report();
    end
endmodule : tb
